// ===== pkg/tmo_pkg.sv
// constants for the timer option and interrupt register block
package tmo_pkg;

    // register byte addresses, index 0 is timer 1, index 1 is timer 2
    localparam logic [1:0][31:0] PEND_ADDR = {32'h4000_a804, 32'h4000_a800};
    localparam logic [1:0][31:0] MISS_ADDR = {32'h4000_a81c, 32'h4000_a818};
    localparam logic [1:0][31:0] IEN_ADDR  = {32'h4000_a844, 32'h4000_a840};
    localparam logic [1:0][31:0] C4_ADDR   = {32'h4000_f040, 32'h4000_e040};
    localparam logic [1:0][31:0] OPT_ADDR  = {32'h4000_f050, 32'h4000_e050};
    localparam logic [31:0]      SUM_STAT_ADDR = 32'h4000_a860;
    localparam logic [31:0]      SUM_MASK_ADDR = 32'h4000_a864;

    // field widths and positions
    localparam int TIMERS     = 2;
    localparam int CHANS      = 4;
    localparam int VAL_W      = 16;
    localparam int FLAG_W     = 7;
    localparam int OPT_W      = 8;
    localparam int UPD_BIT    = 0;
    localparam int CC_LSB     = 1;
    localparam int TRIG_BIT   = 6;
    localparam int MISS_LSB   = 9;
    localparam int SEL_LSB    = 0;
    localparam int GATE_BIT   = 2;
    localparam int RSVD_BIT   = 3;
    localparam int REMAP_LSB  = 4;

    // writable bits
    localparam logic [6:0]      FLAG_MASK = 7'h5f;
    localparam logic [1:0][7:0] OPT_MASK  = {8'hff, 8'h0f};
    localparam logic [1:0]      SUM_MASK  = 2'h3;

    // reset values
    localparam logic [7:0]  OPT_RST   = 8'h00;
    localparam logic [6:0]  FLAG_RST  = 7'h00;
    localparam logic [3:0]  MISS_RST  = 4'h0;
    localparam logic [15:0] VAL_RST   = 16'h0000;

    // external trigger selections
    localparam logic [1:0] TRIG_PCLK  = 2'h0;
    localparam logic [1:0] TRIG_1KHZ  = 2'h1;
    localparam logic [1:0] TRIG_32KHZ = 2'h2;
    localparam logic [1:0] TRIG_PIN   = 2'h3;

    // port a bit per timer 2 channel, two bits each, channel 4 first
    localparam logic [7:0] PA_MAP = 8'h9c;
    // port b bit of channel k is k + PB_OFS
    localparam int         PB_OFS = 1;

endpackage : tmo_pkg

// ===== pkg/tmo_opt_if.sv
// option fields and selected triggers between register file and pin mux
`timescale 1ns/1ps
`default_nettype none
interface tmo_opt_if;
    logic [1:0][1:0] trig_sel;
    logic [1:0]      gate_en;
    logic [3:0]      remap;
    logic [1:0]      ext_trig;

    modport regs (output trig_sel, output gate_en, output remap,
                  input ext_trig);
    modport pins (input trig_sel, input gate_en, input remap,
                  output ext_trig);
endinterface : tmo_opt_if
`default_nettype wire

// ===== logic/tmo_pin_mux.sv
// pin synchronisers, external trigger select and timer 2 channel remap
`timescale 1ns/1ps
`default_nettype none
module tmo_pin_mux (
    input  wire logic  pclk,
    input  wire logic  presetn,
    tmo_opt_if.pins    opt,
    input  wire logic [1:0] timer_clock_pin,
    input  wire logic [1:0] timer_gate_input,
    input  wire logic       ref_1khz_clk,
    input  wire logic       ref_32khz_clk,
    input  wire logic [3:0] chan_drive,
    input  wire logic [3:0] chan_oe_req,
    input  wire logic [3:0] pa_in,
    input  wire logic [4:1] pb_in,
    output logic      [3:0] pa_out,
    output logic      [3:0] pa_oe,
    output logic      [4:1] pb_out,
    output logic      [4:1] pb_oe,
    output logic      [3:0] chan_level
);
    localparam int RAW_W = 14;

    logic [RAW_W-1:0] raw;
    logic [RAW_W-1:0] sync1_q;
    logic [RAW_W-1:0] sync2_q;
    logic [1:0]       clk_s;
    logic [1:0]       gate_s;
    logic             k1_s;
    logic             k32_s;
    logic [3:0]       pa_s;
    logic [4:1]       pb_s;
    logic [1:0]       trig_d;
    logic [1:0]       trig_q;
    logic [3:0]       pa_d;
    logic [3:0]       pa_oe_d;
    logic [4:1]       pb_d;
    logic [4:1]       pb_oe_d;
    logic [3:0]       lvl_d;

    assign raw = {pb_in, pa_in, ref_32khz_clk, ref_1khz_clk,
                  timer_gate_input, timer_clock_pin};

    // two-stage synchroniser for every pin input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    assign {pb_s, pa_s, k32_s, k1_s, gate_s, clk_s} = sync2_q;

    // trigger selection per timer
    genvar t;
    generate
        for (t = 0; t < tmo_pkg::TIMERS; t++)
        begin : g_trig
            always_comb
            begin
                unique case (opt.trig_sel[t])
                    tmo_pkg::TRIG_PCLK:  trig_d[t] = 1'b1;
                    tmo_pkg::TRIG_1KHZ:  trig_d[t] = k1_s;
                    tmo_pkg::TRIG_32KHZ: trig_d[t] = k32_s;
                    tmo_pkg::TRIG_PIN:
                        trig_d[t] = clk_s[t] &
                                    (gate_s[t] | ~opt.gate_en[t]);
                    default:             trig_d[t] = 1'b0;
                endcase
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trig_q <= '0;
        else
            trig_q <= trig_d;
    end

    assign opt.ext_trig = trig_q;

    // timer 2 channel to port a or port b
    always_comb
    begin
        pa_d    = '0;
        pa_oe_d = '0;
        pb_d    = '0;
        pb_oe_d = '0;
        lvl_d   = '0;
        for (int k = 0; k < tmo_pkg::CHANS; k++)
        begin
            pa_d[tmo_pkg::PA_MAP[2*k+:2]]    = chan_drive[k];
            pa_oe_d[tmo_pkg::PA_MAP[2*k+:2]] = chan_oe_req[k] &
                                               ~opt.remap[k];
            pb_d[k+tmo_pkg::PB_OFS]          = chan_drive[k];
            pb_oe_d[k+tmo_pkg::PB_OFS]       = chan_oe_req[k] & opt.remap[k];
            lvl_d[k] = opt.remap[k] ? pb_s[k+tmo_pkg::PB_OFS]
                                    : pa_s[tmo_pkg::PA_MAP[2*k+:2]];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pa_out     <= '0;
            pa_oe      <= '0;
            pb_out     <= '0;
            pb_oe      <= '0;
            chan_level <= '0;
        end
        else
        begin
            pa_out     <= pa_d;
            pa_oe      <= pa_oe_d;
            pb_out     <= pb_d;
            pb_oe      <= pb_oe_d;
            chan_level <= lvl_d;
        end
    end

endmodule : tmo_pin_mux
`default_nettype wire

// ===== logic/tmo_regs.sv
// timer option, channel 4 value and interrupt registers on apb
//
// Contract
// - channel 4 value acts like channel 1
// - gate enable ands clock pin with gate
// - trigger select picks pclk, 1k, 32k, pin
// - timer 2 option bits remap channel pins
// - enable bits 6, 4..1, 0 read-write
// - pending flags at same bit positions
// - reserved read-only fields may change; ignored; the code stores option bit 3 as written in both timers
// - overrun bits 12..9 per channel
// - reset clears all these registers
// - update on wrap unless disabled, or software
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tmo_regs (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [1:0]            cnt_wrap,
    input  wire logic [1:0]            update_disable,
    input  wire logic [1:0]            sw_update,
    input  wire logic [1:0]            trig_event,
    input  wire logic [1:0][3:0]       cc_event,
    input  wire logic [1:0]            chan4_input_mode,
    input  wire logic [1:0]            chan4_preload,
    input  wire logic [1:0][15:0]      counter_value,
    input  wire logic                  timer1_clock_pin,
    input  wire logic                  timer2_clock_pin,
    input  wire logic                  timer1_gate_input,
    input  wire logic                  timer2_gate_input,
    input  wire logic                  ref_1khz_clk,
    input  wire logic                  ref_32khz_clk,
    input  wire logic [3:0]            timer2_chan_drive,
    input  wire logic [3:0]            timer2_chan_oe_req,
    input  wire logic [3:0]            pa_in,
    input  wire logic [4:1]            pb_in,
    output logic      [3:0]            pa_out,
    output logic      [3:0]            pa_oe,
    output logic      [4:1]            pb_out,
    output logic      [4:1]            pb_oe,
    output logic      [3:0]            timer2_chan_level,
    output logic      [1:0]            ext_trigger,
    output logic      [1:0]            update_event,
    output logic      [1:0][15:0]      chan4_active_value,
    output logic      [1:0]            timer_irq,
    output logic                       irq
);
    localparam int T = tmo_pkg::TIMERS;

    logic [T-1:0][7:0]  opt_q;
    logic [T-1:0][6:0]  ien_q;
    logic [T-1:0][6:0]  pend_q;
    logic [T-1:0][3:0]  miss_q;
    logic [T-1:0][15:0] c4_q;
    logic [T-1:0][15:0] c4_act_q;
    logic [T-1:0]       upd_q;
    logic [T-1:0]       tirq_q;
    logic [T-1:0]       upd_d;
    logic [T-1:0][6:0]  pend_set;
    logic [T-1:0][6:0]  pend_clr;
    logic [T-1:0][3:0]  miss_set;
    logic [T-1:0][3:0]  miss_clr;
    logic [1:0]         sum_q;
    logic [1:0]         sum_mask_q;
    logic [1:0]         sum_set;
    logic [1:0]         sum_clr;
    logic               irq_q;
    logic               pready_q;
    logic               pslverr_q;
    logic [31:0]        prdata_q;
    logic [31:0]        rd_d;
    logic               hit_d;
    logic               take;
    logic               done;
    logic               wr;

    tmo_opt_if o ();

    // apb: one wait state, answer from flops
    assign take = psel & penable & ~pready_q;
    assign done = psel & penable & pready_q;
    assign wr   = done & pwrite;

    always_comb
    begin
        rd_d  = '0;
        hit_d = 1'b0;
        for (int t = 0; t < T; t++)
        begin
            if (paddr == tmo_pkg::PEND_ADDR[t])
            begin
                rd_d  = 32'(pend_q[t]);
                hit_d = 1'b1;
            end
            if (paddr == tmo_pkg::MISS_ADDR[t])
            begin
                rd_d  = 32'({miss_q[t], 9'h000});
                hit_d = 1'b1;
            end
            if (paddr == tmo_pkg::IEN_ADDR[t])
            begin
                rd_d  = 32'(ien_q[t]);
                hit_d = 1'b1;
            end
            if (paddr == tmo_pkg::C4_ADDR[t])
            begin
                rd_d  = 32'(c4_q[t]);
                hit_d = 1'b1;
            end
            if (paddr == tmo_pkg::OPT_ADDR[t])
            begin
                rd_d  = 32'(opt_q[t]);
                hit_d = 1'b1;
            end
        end
        if (paddr == tmo_pkg::SUM_STAT_ADDR)
        begin
            rd_d  = 32'(sum_q);
            hit_d = 1'b1;
        end
        if (paddr == tmo_pkg::SUM_MASK_ADDR)
        begin
            rd_d  = 32'(sum_mask_q);
            hit_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
        else
        begin
            pready_q  <= take;
            pslverr_q <= take & ~hit_d;
            if (take)
                prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
        end
    end

    // per-timer registers
    genvar t;
    generate
        for (t = 0; t < T; t++)
        begin : g_tmr
            always_comb
            begin
                upd_d[t] = (cnt_wrap[t] & ~update_disable[t]) |
                           sw_update[t];
                pend_set[t] = '0;
                pend_set[t][tmo_pkg::UPD_BIT] = upd_d[t];
                pend_set[t][tmo_pkg::CC_LSB+:tmo_pkg::CHANS] = cc_event[t];
                pend_set[t][tmo_pkg::TRIG_BIT] = trig_event[t];
                pend_clr[t] = (wr && paddr == tmo_pkg::PEND_ADDR[t]) ?
                              pwdata[6:0] & tmo_pkg::FLAG_MASK : '0;
                miss_clr[t] = (wr && paddr == tmo_pkg::MISS_ADDR[t]) ?
                              pwdata[tmo_pkg::MISS_LSB+:tmo_pkg::CHANS]
                              : '0;
                miss_set[t] = cc_event[t] &
                              pend_q[t][tmo_pkg::CC_LSB+:tmo_pkg::CHANS] &
                              ~pend_clr[t][tmo_pkg::CC_LSB+:tmo_pkg::CHANS];
            end

            // pending flags: set wins over a same-cycle clear
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    pend_q[t] <= tmo_pkg::FLAG_RST;
                else
                    pend_q[t] <= (pend_q[t] & ~pend_clr[t]) |
                                 pend_set[t];
            end

            // overrun flags
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    miss_q[t] <= tmo_pkg::MISS_RST;
                else
                    miss_q[t] <= (miss_q[t] & ~miss_clr[t]) |
                                 miss_set[t];
            end

            // interrupt enables
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ien_q[t] <= tmo_pkg::FLAG_RST;
                else if (wr && paddr == tmo_pkg::IEN_ADDR[t])
                    ien_q[t] <= pwdata[6:0] & tmo_pkg::FLAG_MASK;
            end

            // option register; bit 3 stored as written
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    opt_q[t] <= tmo_pkg::OPT_RST;
                else if (wr && paddr == tmo_pkg::OPT_ADDR[t])
                    opt_q[t] <= pwdata[7:0] & tmo_pkg::OPT_MASK[t];
            end

            // channel 4 value: buffer in compare use, capture in input use
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    c4_q[t] <= tmo_pkg::VAL_RST;
                else if (chan4_input_mode[t] && cc_event[t][3])
                    c4_q[t] <= counter_value[t];
                else if (wr && paddr == tmo_pkg::C4_ADDR[t])
                    c4_q[t] <= pwdata[15:0];
            end

            // active compare value, preloaded at update when enabled
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    c4_act_q[t] <= tmo_pkg::VAL_RST;
                else if (!chan4_input_mode[t] &&
                         (!chan4_preload[t] || upd_d[t]))
                    c4_act_q[t] <= c4_q[t];
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    upd_q[t]  <= 1'b0;
                    tirq_q[t] <= 1'b0;
                end
                else
                begin
                    upd_q[t]  <= upd_d[t];
                    tirq_q[t] <= |(pend_q[t] & ien_q[t]);
                end
            end

            assign o.trig_sel[t] = opt_q[t][tmo_pkg::SEL_LSB+:2];
            assign o.gate_en[t]  = opt_q[t][tmo_pkg::GATE_BIT];
        end
    endgenerate

    assign o.remap = opt_q[1][tmo_pkg::REMAP_LSB+:4];

    // summary status: overrun events, cleared by reading what was seen
    always_comb
    begin
        for (int i = 0; i < T; i++)
            sum_set[i] = |miss_set[i];
        sum_clr = (done && !pwrite && paddr == tmo_pkg::SUM_STAT_ADDR) ?
                  prdata_q[1:0] : 2'h0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sum_q <= 2'h0;
        else
            sum_q <= (sum_q & ~sum_clr) | sum_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sum_mask_q <= 2'h0;
        else if (wr && paddr == tmo_pkg::SUM_MASK_ADDR)
            sum_mask_q <= pwdata[1:0] & tmo_pkg::SUM_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(sum_q & sum_mask_q);
    end

    tmo_pin_mux u_pins (
        .pclk             (pclk),
        .presetn          (presetn),
        .opt              (o.pins),
        .timer_clock_pin  ({timer2_clock_pin, timer1_clock_pin}),
        .timer_gate_input ({timer2_gate_input, timer1_gate_input}),
        .ref_1khz_clk     (ref_1khz_clk),
        .ref_32khz_clk    (ref_32khz_clk),
        .chan_drive       (timer2_chan_drive),
        .chan_oe_req      (timer2_chan_oe_req),
        .pa_in            (pa_in),
        .pb_in            (pb_in),
        .pa_out           (pa_out),
        .pa_oe            (pa_oe),
        .pb_out           (pb_out),
        .pb_oe            (pb_oe),
        .chan_level       (timer2_chan_level)
    );

    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign ext_trigger        = o.ext_trig;
    assign update_event       = upd_q;
    assign chan4_active_value = c4_act_q;
    assign timer_irq          = tirq_q;
    assign irq                = irq_q;

endmodule : tmo_regs
`default_nettype wire

// ===== bench/tmo_regs_monitor.sv
// port-level assertions for the timer option and interrupt registers
`timescale 1ns/1ps
`default_nettype none
module tmo_regs_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  cnt_wrap,
    input wire logic [1:0]  update_disable,
    input wire logic [1:0]  sw_update,
    input wire logic [1:0]  update_event,
    input wire logic [1:0]  timer_irq,
    input wire logic        irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire logic rd_done = psel && penable && pready && !pwrite;

    AST_RST_CLEAR: assert property ($rose(presetn) |->
        !pready && timer_irq == 2'h0 && !irq && update_event == 2'h0)
        else $error("outputs not clear after reset");
    AST_UPD_EVENT: assert property (update_event ==
        $past((cnt_wrap & ~update_disable) | sw_update))
        else $error("update event wrong");
    AST_EN_READ: assert property (rd_done &&
        (paddr == tmo_pkg::IEN_ADDR[0] || paddr == tmo_pkg::IEN_ADDR[1])
        |-> (prdata & 32'hffff_ffa0) == 32'h0)
        else $error("enable read has stray bits");
    AST_PEND_READ: assert property (rd_done &&
        (paddr == tmo_pkg::PEND_ADDR[0] || paddr == tmo_pkg::PEND_ADDR[1])
        |-> (prdata & 32'hffff_e1a0) == 32'h0)
        else $error("pending read has stray bits");
    AST_MISS_READ: assert property (rd_done &&
        (paddr == tmo_pkg::MISS_ADDR[0] || paddr == tmo_pkg::MISS_ADDR[1])
        |-> (prdata & 32'hffff_e180) == 32'h0)
        else $error("overrun read has stray bits");
    AST_C4_READ: assert property (rd_done &&
        (paddr == tmo_pkg::C4_ADDR[0] || paddr == tmo_pkg::C4_ADDR[1])
        |-> prdata[31:16] == 16'h0)
        else $error("channel 4 read too wide");
    AST_OPT1_READ: assert property (rd_done &&
        paddr == tmo_pkg::OPT_ADDR[0] |-> prdata[31:4] == 28'h0)
        else $error("timer 1 option has remap bits");
    AST_RDY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_RDY_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("pready not after one wait state");
    AST_ERR_RDY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");

    cover property (rd_done && pslverr);
    cover property ($rose(irq));
    cover property ($rose(timer_irq[0]));
    cover property (update_event[0] && update_disable[0]);
endmodule : tmo_regs_monitor

bind tmo_regs tmo_regs_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cnt_wrap(cnt_wrap),
    .update_disable(update_disable), .sw_update(sw_update),
    .update_event(update_event), .timer_irq(timer_irq), .irq(irq)
);
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the timer option and interrupt registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic             irq, ref_1khz_clk, ref_32khz_clk, err_s;
    logic             timer1_clock_pin, timer2_clock_pin;
    logic             timer1_gate_input, timer2_gate_input;
    logic [31:0]      paddr, pwdata, prdata, r;
    logic [1:0]       cnt_wrap, update_disable, sw_update, trig_event;
    logic [1:0]       chan4_input_mode, chan4_preload, ext_trigger;
    logic [1:0]       update_event, timer_irq;
    logic [1:0][3:0]  cc_event;
    logic [1:0][15:0] counter_value, chan4_active_value;
    logic [3:0]       timer2_chan_drive, timer2_chan_oe_req, pa_in, pa_out;
    logic [3:0]       pa_oe, timer2_chan_level;
    logic [4:1]       pb_in, pb_out, pb_oe;
    int               errors, checks_done, cyc;

    tmo_regs dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cnt_wrap, .update_disable, .sw_update,
        .trig_event, .cc_event, .chan4_input_mode, .chan4_preload,
        .counter_value, .timer1_clock_pin, .timer2_clock_pin,
        .timer1_gate_input, .timer2_gate_input, .ref_1khz_clk,
        .ref_32khz_clk, .timer2_chan_drive, .timer2_chan_oe_req, .pa_in,
        .pb_in, .pa_out, .pa_oe, .pb_out, .pb_oe, .timer2_chan_level,
        .ext_trigger, .update_event, .chan4_active_value, .timer_irq, .irq
    );

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r     = prdata;
        err_s = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [31:0] a, d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [31:0] a, m, e);
        apb(1'b0, a, 32'h0);
        chk(r & m, e);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : settle

    task automatic ev(input logic [1:0] tr, input logic [1:0][3:0] cc,
                      input logic [1:0] wp, sw);
        @(posedge pclk);
        trig_event <= tr;
        cc_event   <= cc;
        cnt_wrap   <= wp;
        sw_update  <= sw;
        @(posedge pclk);
        {trig_event, cc_event, cnt_wrap, sw_update} <= '0;
    endtask : ev

    task automatic trg(input logic [7:0] o, input logic p, g, k1, k32, x);
        wr(tmo_pkg::OPT_ADDR[0], {24'h0, o});
        timer1_clock_pin  <= p;
        timer1_gate_input <= g;
        ref_1khz_clk      <= k1;
        ref_32khz_clk     <= k32;
        settle(4);
        chk({31'h0, ext_trigger[0]}, {31'h0, x});
    endtask : trg

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, cnt_wrap, update_disable,
         sw_update, trig_event, cc_event, chan4_input_mode, chan4_preload,
         counter_value, timer1_clock_pin, timer2_clock_pin,
         timer1_gate_input, timer2_gate_input, ref_1khz_clk, ref_32khz_clk,
         timer2_chan_drive, timer2_chan_oe_req, pa_in, pb_in} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int t = 0; t < 2; t++)
        begin
            rd(tmo_pkg::PEND_ADDR[t], 32'hffff_ffff, 32'h0);
            rd(tmo_pkg::MISS_ADDR[t], 32'hffff_ffff, 32'h0);
            rd(tmo_pkg::IEN_ADDR[t], 32'hffff_ffff, 32'h0);
            rd(tmo_pkg::C4_ADDR[t], 32'hffff_ffff, 32'h0);
            rd(tmo_pkg::OPT_ADDR[t], 32'hffff_ffff, 32'h0);
            wr(tmo_pkg::IEN_ADDR[t], 32'hffff_ffff);
            rd(tmo_pkg::IEN_ADDR[t], 32'hffff_ffff, 32'h5f);
        end
        wr(tmo_pkg::OPT_ADDR[0], 32'h0000_00f7);
        rd(tmo_pkg::OPT_ADDR[0], 32'hffff_ffff, 32'h07);
        wr(tmo_pkg::OPT_ADDR[1], 32'h0000_00f7);
        rd(tmo_pkg::OPT_ADDR[1], 32'hffff_ffff, 32'hf7);
        rd(32'h4000_a808, 32'hffff_ffff, 32'h0);
        chk({31'h0, err_s}, 32'h1);
        $display("register access test done");

        wr(tmo_pkg::IEN_ADDR[0], 32'h0);
        update_disable <= 2'h1;
        ev(2'h0, '0, 2'h1, 2'h0);
        rd(tmo_pkg::PEND_ADDR[0], 32'hffff_e1ff, 32'h0);
        ev(2'h1, {4'h0, 4'hf}, 2'h0, 2'h1);
        settle(1);
        chk({30'h0, timer_irq}, 32'h0);
        rd(tmo_pkg::PEND_ADDR[0], 32'hffff_e1ff, 32'h5f);
        update_disable <= 2'h0;
        wr(tmo_pkg::IEN_ADDR[0], 32'h5f);
        settle(1);
        chk({30'h0, timer_irq}, 32'h1);
        wr(tmo_pkg::SUM_MASK_ADDR, 32'h3);
        ev(2'h0, {4'h0, 4'h9}, 2'h0, 2'h0);
        rd(tmo_pkg::MISS_ADDR[0], 32'hffff_ff80, 32'h1200);
        settle(1);
        chk({31'h0, irq}, 32'h1);
        rd(tmo_pkg::SUM_STAT_ADDR, 32'hffff_ffff, 32'h1);
        settle(1);
        chk({31'h0, irq}, 32'h0);
        wr(tmo_pkg::MISS_ADDR[0], 32'h1e00);
        rd(tmo_pkg::MISS_ADDR[0], 32'hffff_ff80, 32'h0);
        wr(tmo_pkg::PEND_ADDR[0], 32'h5f);
        rd(tmo_pkg::PEND_ADDR[0], 32'hffff_e1ff, 32'h0);
        settle(1);
        chk({30'h0, timer_irq}, 32'h0);
        $display("interrupt test done");

        wr(tmo_pkg::C4_ADDR[0], 32'hffff_a5c3);
        rd(tmo_pkg::C4_ADDR[0], 32'hffff_ffff, 32'ha5c3);
        chan4_preload <= 2'h1;
        settle(1);
        chk({16'h0, chan4_active_value[0]}, 32'ha5c3);
        wr(tmo_pkg::C4_ADDR[0], 32'h1234);
        settle(2);
        chk({16'h0, chan4_active_value[0]}, 32'ha5c3);
        ev(2'h0, '0, 2'h0, 2'h1);
        settle(2);
        chk({16'h0, chan4_active_value[0]}, 32'h1234);
        @(posedge pclk);
        chan4_input_mode <= 2'h1;
        counter_value[0] <= 16'h0bee;
        ev(2'h0, {4'h0, 4'h8}, 2'h0, 2'h0);
        rd(tmo_pkg::C4_ADDR[0], 32'hffff_ffff, 32'h0bee);
        $display("channel 4 test done");

        wr(tmo_pkg::OPT_ADDR[1], 32'hf0);
        timer2_chan_drive  <= 4'h2;
        timer2_chan_oe_req <= 4'hf;
        pb_in              <= 4'h2;
        pa_in              <= 4'h7;
        settle(4);
        chk({pb_oe, pb_out, pa_oe, timer2_chan_level}, 32'hf202);
        chk({31'h0, ext_trigger[1]}, 32'h1);
        wr(tmo_pkg::OPT_ADDR[1], 32'h0);
        pa_in <= 4'h8;
        pb_in <= 4'hd;
        settle(4);
        chk({pa_oe, pa_out, pb_oe, timer2_chan_level}, 32'hf802);
        $display("pin remap test done");

        trg(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        trg(8'h01, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        trg(8'h02, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        trg(8'h03, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        trg(8'h07, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        trg(8'h07, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        $display("trigger select test done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
